// ===== fcif_defines.svh
// Constants of the flash command interface host controller
//
// Notes on behaviour
// [RL1] Device drops to read mode when a write breaks every valid sequence.
// [RL2] Read/reset is one write of F0, or 555/AA, 2AA/55, any/F0.
// [RL3] Reset during chip erase aborts it in about 10 us; data invalid.
// [RL4] Auto select is 555/AA, 2AA/55, 555/90; mode holds until next command.
// [RL5] In auto select, bit0 low reads maker code, bit0 high part code.
// [RL6] Codes also read by plain read with identification level on bit 9.
// [RL7] Program is three unlock writes with A0, then target address and byte.
// [RL8] Device ignores all writes while a byte program runs.
// [RL9] Reads during programming return the status byte.
// [RL10] Success returns to read mode; failure keeps status until a reset.
// [RL11] Programming only turns ones to zeros; only erase restores ones.
// [RL12] Unlock bypass is 555/AA, 2AA/55, 555/20.
// [RL13] Bypass program is any/A0 then target; bypass exit is any/90, any/00.
// [RL14] Chip erase is six writes ending 555/10; status read until finished.
// [RL15] Device matches command addresses on bits 0 to 10 only.
// [RL16] Address latched on later fall, data on earlier rise; read enable high.
// [RL17] In bypass mode only bypass program and exit are accepted. The host also admits resets and reads in bypass mode.
// [RL18] Status: bit 7 polling, bit 6 toggles per read, bit 5 failure.
// [RL19] Device starts in read mode with nothing pending after power-up.
`ifndef FCIF_DEFINES_SVH
`define FCIF_DEFINES_SVH

// ==========================================================
// Software register offsets
`define FC_R_CMD 4'h0
`define FC_R_ADDR 4'h1
`define FC_R_BYTE 4'h2
`define FC_R_STAT 4'h3
`define FC_R_ISTAT 4'h4
`define FC_R_MASK 4'h5
`define FC_R_RDATA 4'h6

// ==========================================================
// Status register bits
`define FC_S_BUSY 0
`define FC_S_BYP 1
`define FC_S_AUTO 2
`define FC_S_ERR 3
`define FC_S_ERASE 4
`define FC_S_BYTE_LO 8
`define FC_S_BYTE_HI 15

// ==========================================================
// Event bits
`define FC_EV_DONE 0
`define FC_EV_FAIL 1
`define FC_EV_REF 2
`define FC_EV_W 3

// ==========================================================
// Command addresses and codes
`define FC_A_555 16'h0555
`define FC_A_2AA 16'h02AA
`define FC_A_ANY 16'h0000
`define FC_D_AA 8'hAA
`define FC_D_55 8'h55
`define FC_D_F0 8'hF0
`define FC_D_90 8'h90
`define FC_D_A0 8'hA0
`define FC_D_20 8'h20
`define FC_D_80 8'h80
`define FC_D_10 8'h10
`define FC_D_00 8'h00

// ==========================================================
// Sequence lengths and step positions
`define FC_LEN_ONE 3'h1
`define FC_LEN_TWO 3'h2
`define FC_LEN_THREE 3'h3
`define FC_LEN_PROG 3'h4
`define FC_LEN_ERASE 3'h6
`define FC_STEP_H0 3'h0
`define FC_STEP_H1 3'h1
`define FC_STEP_E0 3'h3
`define FC_STEP_E1 3'h4
`define FC_STEP_E2 3'h5
`define FC_STEP_PD 3'h3
`define FC_STEP_BD 3'h1

// ==========================================================
// Status byte bits
`define FC_TOG_BIT 6
`define FC_FAIL_BIT 5

// ==========================================================
// Pin cycle phases
`define FC_PH_IDLE 2'h0
`define FC_PH_LOW 2'h1
`define FC_PH_RISE 2'h2
`define FC_PH_END 2'h3

// ==========================================================
// Timing
`define FC_CLK_NS 100
`define FC_ABORT_NS 10000
`define FC_ABORT_CYC ((`FC_ABORT_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)

`endif

// ===== fcif_pkg.sv
// Types of the flash command interface host controller
package fcif_pkg;

	// Commands that software may order
	typedef enum logic [3:0] {
		FC_RST1 = 4'h0,
		FC_RST3 = 4'h1,
		FC_AUTO = 4'h2,
		FC_PROG = 4'h3,
		FC_UBP = 4'h4,
		FC_BPROG = 4'h5,
		FC_BEXIT = 4'h6,
		FC_ERASE = 4'h7,
		FC_READ = 4'h8,
		FC_SIG = 4'h9
	} fcif_cmd_t;

	// Controller states, Gray along the usual path
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CHECK = 3'h1,
		S_CHKW = 3'h3,
		S_RUN = 3'h2,
		S_WAIT = 3'h6,
		S_POLL = 3'h7,
		S_POLLW = 3'h5,
		S_ABORT = 3'h4
	} fcif_state_t;

endpackage

// ===== fcif_bus_if.sv
// Request and answer bundle between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none

interface fcif_bus_if;
	logic req;
	logic wr;
	logic id;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;

	modport ctl (output req, wr, id, addr, wdata, input done, rdata);
	modport eng (input req, wr, id, addr, wdata, output done, rdata);
endinterface

`default_nettype wire

// ===== fcif_seq.sv
// Command sequence table: address and byte of each bus step
`timescale 1ns/1ps
`default_nettype none
`include "fcif_defines.svh"

module fcif_seq
	import fcif_pkg::*;
(
	// Command position
	input wire fcif_cmd_t cmd,
	input wire logic [2:0] step,
	// Target
	input wire logic [15:0] tgt_addr,
	input wire logic [7:0] tgt_byte,
	// Step description
	output logic op_wr,
	output logic op_id,
	output logic op_last,
	output logic op_unl,
	output logic [15:0] op_addr,
	output logic [7:0] op_data
);

	// ==========================================================
	// Command classes
	wire unl = cmd == FC_RST3 || cmd == FC_AUTO || cmd == FC_PROG
		|| cmd == FC_UBP || cmd == FC_ERASE;
	wire rd = cmd == FC_READ || cmd == FC_SIG;
	wire etail = cmd == FC_ERASE && step >= `FC_STEP_E0;

	// Sequence length per command
	wire [2:0] len = (cmd == FC_ERASE) ? `FC_LEN_ERASE :
		(cmd == FC_PROG) ? `FC_LEN_PROG :
		(cmd == FC_BPROG || cmd == FC_BEXIT) ? `FC_LEN_TWO :
		unl ? `FC_LEN_THREE : `FC_LEN_ONE;

	// Unlock pairs, also repeated inside the erase tail
	wire u0 = (unl && step == `FC_STEP_H0) || (etail && step == `FC_STEP_E0); // RL14
	wire u1 = (unl && step == `FC_STEP_H1) || (etail && step == `FC_STEP_E1); // RL14
	wire tstep = (cmd == FC_PROG && step == `FC_STEP_PD)
		|| (cmd == FC_BPROG && step == `FC_STEP_BD); // RL7 RL13

	// ==========================================================
	// Step outputs
	assign op_wr = !rd;
	assign op_id = cmd == FC_SIG; // RL6
	assign op_last = 3'(step + 3'h1) == len;
	assign op_unl = unl && step == `FC_STEP_H0;
	assign op_addr = u1 ? `FC_A_2AA :
		(tstep || rd) ? tgt_addr :
		unl ? `FC_A_555 : `FC_A_ANY;
	// Command bytes per step
	assign op_data = u0 ? `FC_D_AA :
		u1 ? `FC_D_55 :
		tstep ? tgt_byte :
		(cmd == FC_ERASE) ? ((step == `FC_STEP_E2) ? `FC_D_10 : `FC_D_80) : // RL14
		(cmd == FC_RST1 || cmd == FC_RST3) ? `FC_D_F0 : // RL2
		(cmd == FC_AUTO) ? `FC_D_90 : // RL4
		(cmd == FC_PROG || cmd == FC_BPROG) ? `FC_D_A0 : // RL7 RL13
		(cmd == FC_UBP) ? `FC_D_20 : // RL12
		(cmd == FC_BEXIT && step == `FC_STEP_H0) ? `FC_D_90 : `FC_D_00; // RL13

endmodule // fcif_seq

`default_nettype wire

// ===== fcif_pins.sv
// Pin engine: one bus write or bus read on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "fcif_defines.svh"

module fcif_pins
	import fcif_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Requests
	fcif_bus_if.eng bif,
	// Flash pins
	output logic [15:0] addr_in,
	output logic [7:0] data_io_out,
	input wire logic [7:0] data_io_in,
	output logic data_io_oe_n,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic id_level_input
);

	logic [1:0] phase;
	logic is_wr;
	logic done;
	logic [7:0] rdata;

	assign bif.done = done;
	assign bif.rdata = rdata;

	// ==========================================================
	// Cycle: set up, strobe low, rise, release
	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (reset)
		begin
			phase <= `FC_PH_IDLE;
			is_wr <= 1'b0;
			rdata <= 8'h00;
			addr_in <= 16'h0000;
			data_io_out <= 8'h00;
			data_io_oe_n <= 1'b1;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			wr_en_n <= 1'b1;
			id_level_input <= 1'b0;
		end
		else
		begin
			case (phase)
				`FC_PH_IDLE:
				begin
					if (bif.req)
					begin
						addr_in <= bif.addr; // RL16
						data_io_out <= bif.wdata;
						is_wr <= bif.wr;
						chip_en_n <= 1'b0;
						data_io_oe_n <= !bif.wr;
						out_en_n <= bif.wr; // RL16
						id_level_input <= bif.id && !bif.wr; // RL6
						phase <= `FC_PH_LOW;
					end
				end
				`FC_PH_LOW:
				begin
					wr_en_n <= !is_wr;
					phase <= `FC_PH_RISE;
				end
				`FC_PH_RISE:
				begin
					wr_en_n <= 1'b1; // RL16
					if (!is_wr)
						rdata <= data_io_in;
					phase <= `FC_PH_END;
				end
				default:
				begin
					chip_en_n <= 1'b1;
					out_en_n <= 1'b1;
					data_io_oe_n <= 1'b1;
					id_level_input <= 1'b0;
					done <= 1'b1;
					phase <= `FC_PH_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_write_oe_high: assert property (@(posedge clk) disable iff (reset) // RL16
		!wr_en_n |-> out_en_n && !chip_en_n && !data_io_oe_n)
		else $error("read enable or data not held during write strobe");
	a_we_one_cycle: assert property (@(posedge clk) disable iff (reset) // RL16
		$fell(wr_en_n) |=> wr_en_n && $stable(addr_in) && $stable(data_io_out))
		else $error("write strobe width or address changed");
	a_done_latency: assert property (@(posedge clk) disable iff (reset)
		(bif.req && phase == `FC_PH_IDLE) |-> !done ##4 done)
		else $error("pin cycle did not end four cycles after request");

endmodule // fcif_pins

`default_nettype wire

// ===== fcif_host.sv
// Flash command interface host controller, top level
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fcif_defines.svh"

module fcif_host
	import fcif_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Software register port
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic irq,
	// Flash pins
	output logic [15:0] addr_in,
	output logic [7:0] data_io_out,
	input wire logic [7:0] data_io_in,
	output logic data_io_oe_n,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic id_level_input
);

	fcif_bus_if bif();

	fcif_state_t state;
	fcif_cmd_t cmd;
	logic [2:0] step;
	logic [15:0] tgt_addr;
	logic [7:0] tgt_byte;
	logic [7:0] rd_byte;
	logic [`FC_EV_W-1:0] int_stat;
	logic [`FC_EV_W-1:0] int_mask;
	logic bypass;
	logic autosel;
	logic error;
	logic erasing;
	logic abort_pend;
	logic poll_first;
	logic fail_seen;
	logic tog;
	logic [6:0] abort_cnt;
	logic req;
	logic req_wr;
	logic req_id;
	logic [15:0] req_addr;
	logic [7:0] req_data;
	logic op_wr;
	logic op_id;
	logic op_last;
	logic op_unl;
	logic [15:0] op_addr;
	logic [7:0] op_data;

	// ==========================================================
	// Sub-blocks
	fcif_pins u_pins (
		.clk(clk),
		.reset(reset),
		.bif(bif.eng),
		.addr_in(addr_in),
		.data_io_out(data_io_out),
		.data_io_in(data_io_in),
		.data_io_oe_n(data_io_oe_n),
		.chip_en_n(chip_en_n),
		.out_en_n(out_en_n),
		.wr_en_n(wr_en_n),
		.id_level_input(id_level_input)
	);

	fcif_seq u_seq (
		.cmd(cmd),
		.step(step),
		.tgt_addr(tgt_addr),
		.tgt_byte(tgt_byte),
		.op_wr(op_wr),
		.op_id(op_id),
		.op_last(op_last),
		.op_unl(op_unl),
		.op_addr(op_addr),
		.op_data(op_data)
	);

	// Request bundle towards the pin engine
	assign bif.req = req;
	assign bif.wr = req_wr;
	assign bif.id = req_id;
	assign bif.addr = req_addr;
	assign bif.wdata = req_data;

	// ==========================================================
	// Command decode and admission
	wire busy = state != S_IDLE;
	wire wr_cmd = sw_wr && sw_addr == `FC_R_CMD;
	wire [3:0] new_cmd = sw_wdata[3:0];
	wire new_byp = new_cmd == FC_BPROG || new_cmd == FC_BEXIT;
	wire new_rst = new_cmd == FC_RST1 || new_cmd == FC_RST3;
	wire new_plain = new_rst || new_cmd == FC_READ || new_cmd == FC_SIG;
	wire new_known = new_cmd <= FC_SIG;
	// Bypass mode takes only its own commands, resets and reads
	wire cmd_ok = new_known && (bypass ? (new_byp || new_plain) : !new_byp)
		&& (!error || new_rst || new_cmd == FC_READ); // RL17 RL10
	wire start = wr_cmd && !busy && cmd_ok;
	// A reset while erasing aborts the erase
	wire abort_req = wr_cmd && busy && erasing && new_rst; // RL3
	wire new_pgm = new_cmd == FC_PROG || new_cmd == FC_BPROG;

	// ==========================================================
	// Progress terms
	wire is_pe = cmd == FC_PROG || cmd == FC_BPROG || cmd == FC_ERASE;
	wire is_rst = cmd == FC_RST1 || cmd == FC_RST3;
	wire check_bad = state == S_CHKW && bif.done
		&& |(tgt_byte & ~bif.rdata); // RL11
	wire fin_seq = state == S_WAIT && bif.done && op_last;
	wire poll_end = state == S_POLLW && bif.done;
	wire toggling = bif.rdata[`FC_TOG_BIT] != tog; // RL18
	// A reset landing on the closing poll read still aborts
	wire stop_poll = abort_pend || abort_req; // RL3
	wire poll_ok = poll_end && !poll_first && !toggling && !stop_poll;
	wire poll_fail = poll_end && !poll_first && toggling && !stop_poll
		&& bif.rdata[`FC_FAIL_BIT] && fail_seen; // RL18 RL10
	wire abort_end = state == S_ABORT && abort_cnt == 7'h00;
	wire ev_done = (fin_seq && !is_pe && !erasing) || poll_ok || abort_end;
	wire ev_ref = (wr_cmd && !start && !abort_req) || check_bad; // RL8
	wire [`FC_EV_W-1:0] events = {ev_ref, poll_fail, ev_done};
	wire [`FC_EV_W-1:0] w1c = (sw_wr && sw_addr == `FC_R_ISTAT) ?
		sw_wdata[`FC_EV_W-1:0] : {`FC_EV_W{1'b0}};

	// Read data selection
	wire [31:0] stat_word = {16'h0000, rd_byte, 3'h0, erasing, error,
		autosel, bypass, busy};
	wire [31:0] rd_mux = (sw_addr == `FC_R_ADDR) ? {16'h0000, tgt_addr} :
		(sw_addr == `FC_R_BYTE) ? {24'h000000, tgt_byte} :
		(sw_addr == `FC_R_STAT) ? stat_word :
		(sw_addr == `FC_R_ISTAT) ? {29'h00000000, int_stat} :
		(sw_addr == `FC_R_MASK) ? {29'h00000000, int_mask} :
		(sw_addr == `FC_R_RDATA) ? {24'h000000, rd_byte} : 32'h00000000;

	// ==========================================================
	// Software registers, interrupt and read port
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tgt_addr <= 16'h0000;
			tgt_byte <= 8'h00;
			int_stat <= {`FC_EV_W{1'b0}};
			int_mask <= {`FC_EV_W{1'b0}};
			irq <= 1'b0;
			sw_rdata <= 32'h00000000;
		end
		else
		begin
			if (sw_wr && !busy && sw_addr == `FC_R_ADDR)
				tgt_addr <= sw_wdata[15:0];
			if (sw_wr && !busy && sw_addr == `FC_R_BYTE)
				tgt_byte <= sw_wdata[7:0];
			if (sw_wr && sw_addr == `FC_R_MASK)
				int_mask <= sw_wdata[`FC_EV_W-1:0];
			// Set wins over the write-one clear
			int_stat <= (int_stat & ~w1c) | events;
			irq <= |(int_stat & int_mask);
			sw_rdata <= sw_rd ? rd_mux : 32'h00000000;
		end
	end

	// ==========================================================
	// Sequencer state machine
	always_ff @(posedge clk)
	begin
		req <= 1'b0;
		if (reset)
		begin
			state <= S_IDLE; // RL19
			cmd <= FC_RST1;
			step <= 3'h0;
			rd_byte <= 8'h00;
			bypass <= 1'b0;
			autosel <= 1'b0;
			error <= 1'b0;
			erasing <= 1'b0;
			abort_pend <= 1'b0;
			poll_first <= 1'b0;
			fail_seen <= 1'b0;
			tog <= 1'b0;
			abort_cnt <= 7'h00;
			req_wr <= 1'b0;
			req_id <= 1'b0;
			req_addr <= 16'h0000;
			req_data <= 8'h00;
		end
		else
		begin
			if (abort_req)
				abort_pend <= 1'b1; // RL3
			case (state)
				S_IDLE:
				begin
					if (start)
					begin
						cmd <= fcif_cmd_t'(new_cmd);
						step <= 3'h0;
						state <= new_pgm ? S_CHECK : S_RUN;
					end
				end
				S_CHECK:
				begin
					// Read the old byte before programming
					req <= 1'b1;
					req_wr <= 1'b0;
					req_id <= 1'b0;
					req_addr <= tgt_addr;
					state <= S_CHKW;
				end
				S_CHKW:
				begin
					if (bif.done)
					begin
						rd_byte <= bif.rdata;
						state <= check_bad ? S_IDLE : S_RUN; // RL11
					end
				end
				S_RUN:
				begin
					req <= 1'b1;
					req_wr <= op_wr;
					req_id <= op_id;
					req_addr <= op_addr;
					req_data <= op_data;
					state <= S_WAIT;
				end
				S_WAIT:
				begin
					if (bif.done && !op_last)
					begin
						step <= 3'(step + 3'h1); // RL1
						state <= S_RUN;
					end
					else if (fin_seq)
					begin
						if (!op_wr)
							rd_byte <= bif.rdata; // RL5 RL6
						if (is_rst)
							error <= 1'b0; // RL2 RL10
						if (cmd == FC_UBP)
							bypass <= 1'b1; // RL12
						if (cmd == FC_BEXIT)
							bypass <= 1'b0; // RL13
						autosel <= (cmd == FC_AUTO) || (!op_wr && autosel); // RL4
						abort_cnt <= 7'(`FC_ABORT_CYC - 1);
						poll_first <= 1'b1;
						fail_seen <= 1'b0;
						if (cmd == FC_ERASE)
							erasing <= 1'b1;
						state <= is_pe ? S_POLL : (erasing ? S_ABORT : S_IDLE); // RL14 RL3
					end
				end
				S_POLL:
				begin
					// Status read at the target; any address while erasing
					req <= 1'b1;
					req_wr <= 1'b0;
					req_id <= 1'b0;
					req_addr <= tgt_addr;
					state <= S_POLLW;
				end
				S_POLLW:
				begin
					if (bif.done)
					begin
						rd_byte <= bif.rdata; // RL9
						tog <= bif.rdata[`FC_TOG_BIT];
						poll_first <= 1'b0;
						if (stop_poll)
						begin
							abort_pend <= 1'b0;
							cmd <= FC_RST1;
							step <= 3'h0;
							state <= S_RUN; // RL3
						end
						else if (poll_ok)
						begin
							erasing <= 1'b0;
							state <= S_IDLE; // RL10
						end
						else if (poll_fail)
						begin
							error <= 1'b1;
							erasing <= 1'b0;
							state <= S_IDLE; // RL10
						end
						else
						begin
							if (!poll_first && bif.rdata[`FC_FAIL_BIT])
								fail_seen <= 1'b1;
							state <= S_POLL;
						end
					end
				end
				S_ABORT:
				begin
					// Erase abort time: data on the pins is not valid
					abort_cnt <= 7'(abort_cnt - 7'h01);
					if (abort_end)
					begin
						erasing <= 1'b0;
						state <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_refuse_busy: assert property (@(posedge clk) disable iff (reset) // RL8
		(wr_cmd && busy && !abort_req) |=> int_stat[`FC_EV_REF])
		else $error("command during busy not flagged as refused");
	a_bypass_gate: assert property (@(posedge clk) disable iff (reset) // RL17
		(start && bypass) |-> (new_byp || new_plain))
		else $error("non-bypass command started in bypass mode");
	a_unlock_head: assert property (@(posedge clk) disable iff (reset) // RL2
		(state == S_RUN && op_unl) |=> req && req_wr
		&& req_addr == `FC_A_555 && req_data == `FC_D_AA)
		else $error("unlock sequence does not open with 555/AA");
	a_prog_clear_only: assert property (@(posedge clk) disable iff (reset) // RL11
		check_bad |=> state == S_IDLE && int_stat[`FC_EV_REF])
		else $error("program of a zero bit to one not refused");
	a_abort_hold: assert property (@(posedge clk) disable iff (reset) // RL3
		$rose(state == S_ABORT) |-> (state == S_ABORT)[*8])
		else $error("erase abort wait ended too early");
	a_error_sticky: assert property (@(posedge clk) disable iff (reset) // RL10
		(error && !(fin_seq && is_rst)) |=> error)
		else $error("error cleared without a reset command");
	a_irq_follow: assert property (@(posedge clk) disable iff (reset)
		(|(int_stat & int_mask)) |=> irq)
		else $error("interrupt not raised for unmasked event");

endmodule // fcif_host

`default_nettype wire

// ===== fcif_flash_model.sv
// Behavioural flash device seen at the host controller's pins
`timescale 1ns/1ps
`default_nettype none

module fcif_flash_model #(
	parameter logic [7:0] MAKER_ID = 8'h00, // Arbitrary value
	parameter logic [7:0] PART_ID = 8'h01, // Arbitrary value
	parameter int POLLS = 3,
	parameter int ERASE_POLLS = 40
) (
	// Flash pins
	input wire logic [15:0] addr_in,
	input wire logic [7:0] data_io,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic id_level_input,
	output logic [7:0] data_q,
	// Bench control and report
	input wire logic fail_next,
	output int bus_errs
);
	// ==========================================================
	// State, read mode after power-up
	logic [7:0] mem [0:65535];
	logic [15:0] la;
	logic [7:0] pd, last = 8'h00;
	int st = 0, polls = 0;
	logic busy = 0, ers = 0, err = 0, tog = 0, auto = 0, byp = 0, ab = 0, fl = 0;
	wire logic [7:0] stat = {~pd[7], tog, err, 5'h00};
	// Status while busy or failed, codes in identification mode
	wire logic [7:0] q = ab ? ~last : (busy || err) ? stat :
		(auto || id_level_input) ? (addr_in[0] ? PART_ID : MAKER_ID) : mem[addr_in];
	// Released bus shows the inverse of the last byte
	assign data_q = (chip_en_n === 1'h0 && out_en_n === 1'h0) ? q : ~last;

	initial
	begin
		bus_errs = 0;
		foreach (mem[i])
			mem[i] = 8'hFF;
	end

	task automatic start(input logic [7:0] d, input int n, input logic e);
		pd = d;
		polls = n;
		ers = e;
		fl = fail_next;
		busy = 1'h1;
	endtask

	// Decoder: a write fitting no sequence drops to read mode
	task automatic wr_cyc(input logic [15:0] a, input logic [7:0] d);
		int s;
		logic u;
		s = st;
		u = a[10:0] == 11'h555;
		if (busy)
		begin
			if (ers && d == 8'hF0)
			begin
				busy = 1'h0;
				ers = 1'h0;
				ab = 1'h1;
				ab <= #10000 1'h0;
			end
			return;
		end
		st = 0;
		auto = 1'h0;
		case (s)
			0: if (d == 8'hF0) {err, ers} = 2'h0;
				else if (u && d == 8'hAA) st = 1;
				else if (byp && d == 8'hA0) st = 6;
				else if (byp && d == 8'h90) st = 7;
			1, 4: if (a[10:0] == 11'h2AA && d == 8'h55) st = s + 1;
			2: if (d == 8'hF0) {err, ers} = 2'h0;
				else if (u && d == 8'h90) auto = 1'h1;
				else if (u && d == 8'hA0) st = 6;
				else if (u && d == 8'h20) byp = 1'h1;
				else if (u && d == 8'h80) st = 3;
			3: if (u && d == 8'hAA) st = 4;
			5: if (u && d == 8'h10) start(8'hFF, ERASE_POLLS, 1'h1);
			6:
			begin
				mem[a] = mem[a] & d;
				start(d, POLLS, 1'h0);
			end
			7: if (d == 8'h00) byp = 1'h0;
			default: st = 0;
		endcase
	endtask

	// Address on the later fall of the two enables
	always @(negedge wr_en_n or negedge chip_en_n)
		if (!wr_en_n && !chip_en_n)
			la = addr_in;
	// Data on the earlier rise; read enable must stay high
	always @(posedge wr_en_n or posedge chip_en_n)
		if (wr_en_n != chip_en_n)
		begin
			if (!out_en_n)
				bus_errs++;
			wr_cyc(la, data_io);
		end
	// Each read is one poll; the last poll settles the result
	always @(posedge out_en_n)
	begin
		last = q;
		tog = tog ^ (busy | err);
		if (busy && polls-- == 0)
		begin
			busy = 1'h0;
			err = fl;
			if (ers && !fl)
				foreach (mem[i])
					mem[i] = 8'hFF;
			ers = ers & fl;
		end
	end
endmodule // fcif_flash_model

`default_nettype wire

// ===== tb_fcif_host.sv
// Self-checking testbench of the flash command interface host controller
`timescale 1ns/1ps
`default_nettype none
`include "fcif_defines.svh"

module tb_fcif_host
	import fcif_pkg::*;
;
	// ==========================================================
	// Signals
	localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
	localparam logic [7:0] PART = 8'hC3; // Arbitrary value
	logic clk = 1'h0, reset = 1'h1, sw_wr = 1'h0, sw_rd = 1'h0, fail_next = 1'h0;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0, sw_rdata, v;
	logic irq, data_io_oe_n, chip_en_n, out_en_n, wr_en_n, id_level_input;
	logic [15:0] addr_in, a;
	logic [7:0] data_io_out, fl_q, b, shadow [logic [15:0]];
	logic [2:0] msk = 3'h0;
	int mismatches = 0, check_count = 0, cyc = 0, t0, bus_errs;
	// Shared data pins: host drives while its enable is low
	wire logic [7:0] data_io_in = (data_io_oe_n === 1'h0) ? data_io_out : fl_q;

	fcif_host dut_u (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .addr_in(addr_in),
		.data_io_out(data_io_out), .data_io_in(data_io_in), .data_io_oe_n(data_io_oe_n),
		.chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.id_level_input(id_level_input));
	fcif_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash_u (.addr_in(addr_in),
		.data_io(data_io_in), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.id_level_input(id_level_input), .data_q(fl_q), .fail_next(fail_next),
		.bus_errs(bus_errs));

	// ==========================================================
	// Clock and hang ceiling
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			mismatches++;
			print_verdict;
		end
	end

	task automatic print_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] mexp(input logic [15:0] ad);
		return shadow.exists(ad) ? shadow[ad] : 8'hFF;
	endfunction
	// Register port cycles
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		sw_addr <= ad;
		sw_wdata <= d;
		sw_wr <= 1'h1;
		@(posedge clk);
		sw_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] ad);
		@(posedge clk);
		sw_addr <= ad;
		sw_rd <= 1'h1;
		@(posedge clk);
		sw_rd <= 1'h0;
		#1 v = sw_rdata;
	endtask
	// Command, wait for idle, check and clear events
	task automatic op(input logic [3:0] c, input logic [2:0] m, input logic [2:0] e);
		int n;
		n = 0;
		wr(`FC_R_CMD, {28'h0, c});
		do
		begin
			rd(`FC_R_STAT);
			n++;
		end
		while (v[`FC_S_BUSY] !== 1'h0 && n < 3000);
		chk("busy", 32'h0, {31'h0, v[`FC_S_BUSY]});
		rd(`FC_R_ISTAT);
		chk("int_stat", {29'h0, e}, v & {29'h0, m});
		if (m == 3'h7)
			chk("irq", {31'h0, |(e & msk)}, {31'h0, irq});
		wr(`FC_R_ISTAT, 32'h7);
		@(posedge clk);
		#1 chk("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic rdc(input logic [15:0] ad, input logic [3:0] c, input logic [7:0] e);
		wr(`FC_R_ADDR, {16'h0, ad});
		op(c, 3'h4, 3'h0);
		rd(`FC_R_RDATA);
		chk("rdata", {24'h0, e}, v);
	endtask
	task automatic pgm(input logic [15:0] ad, input logic [7:0] d, input logic [3:0] c,
		input logic [2:0] e);
		wr(`FC_R_ADDR, {16'h0, ad});
		wr(`FC_R_BYTE, {24'h0, d});
		op(c, 3'h7, e);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hB2D67B52));
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		for (int i = 0; i < 16; i++)
		begin
			rd(i[3:0]);
			chk("reg", 32'h0, v);
		end
		chk("irq", 32'h0, {31'h0, irq});
		// Identification by command, then by level on bit 9
		op(FC_AUTO, 3'h4, 3'h0);
		rd(`FC_R_STAT);
		chk("auto", 32'h1, {31'h0, v[`FC_S_AUTO]});
		rdc(16'hFFFC, FC_READ, MAKER);
		rdc(16'h0001, FC_READ, PART);
		op(FC_RST1, 3'h4, 3'h0);
		rdc(16'h0001, FC_READ, 8'hFF);
		rdc(16'h0201, FC_SIG, PART);
		rdc(16'h0200, FC_SIG, MAKER);
		// Done masked; random programs and a zero at the top address
		wr(`FC_R_MASK, 32'h2);
		msk = 3'h2;
		rd(`FC_R_MASK);
		chk("mask", 32'h2, v);
		for (int i = 0; i < 6; i++)
		begin
			a = i ? 16'($urandom) : 16'hFFFF;
			b = i ? 8'($urandom) & mexp(a) : 8'h00;
			shadow[a] = b;
			pgm(a, b, FC_PROG, 3'h1);
			rdc(a, FC_READ, b);
		end
		pgm(16'hFFFF, 8'h01, FC_PROG, 3'h4);
		rdc(16'hFFFF, FC_READ, 8'h00);
		op(4'hC, 3'h7, 3'h4);
		// Failure raises the unmasked interrupt and holds until reset
		fail_next <= 1'h1;
		pgm(16'h0555, 8'h00, FC_PROG, 3'h2);
		fail_next <= 1'h0;
		rd(`FC_R_STAT);
		chk("err", 32'h1, {31'h0, v[`FC_S_ERR]});
		op(FC_PROG, 3'h7, 3'h4);
		op(FC_RST3, 3'h4, 3'h0);
		rd(`FC_R_STAT);
		chk("err", 32'h0, {31'h0, v[`FC_S_ERR]});
		rdc(16'h0555, FC_READ, 8'h00);
		// Bypass mode
		op(FC_UBP, 3'h4, 3'h0);
		rd(`FC_R_STAT);
		chk("byp", 32'h1, {31'h0, v[`FC_S_BYP]});
		op(FC_PROG, 3'h4, 3'h4);
		a = 16'($urandom);
		b = 8'($urandom) & mexp(a);
		pgm(a, b, FC_BPROG, 3'h1);
		rdc(a, FC_READ, b);
		op(FC_BEXIT, 3'h4, 3'h0);
		rd(`FC_R_STAT);
		chk("byp", 32'h0, {31'h0, v[`FC_S_BYP]});
		op(FC_BPROG, 3'h4, 3'h4);
		// Erase, then a reset in mid-erase
		op(FC_ERASE, 3'h7, 3'h1);
		rdc(a, FC_READ, 8'hFF);
		rdc(16'hFFFF, FC_READ, 8'hFF);
		wr(`FC_R_CMD, {28'h0, FC_ERASE});
		wr(`FC_R_CMD, {28'h0, FC_AUTO});
		repeat (100) @(posedge clk);
		t0 = cyc;
		op(FC_RST1, 3'h4, 3'h4);
		chk("abort", 32'h1, {31'h0, cyc - t0 >= 100});
		rd(`FC_R_STAT);
		chk("stat", 32'h0, {27'h0, v[4:0]});
		chk("bus", 32'h0, 32'(bus_errs));
		print_verdict;
	end
endmodule // tb_fcif_host

`default_nettype wire
